//--- lagc_timing_regs.sv
`timescale 1ns/1ns
module lagc_timing_regs (
  input  wire logic                                i_core_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_fs_tick,
  input  wire logic                                i_agc_enable,
  input  wire logic                                i_reg_sel,
  input  wire logic                                i_reg_we,
  input  wire logic [7:0]                          i_reg_addr,
  input  wire logic [7:0]                          i_reg_wdata,
  input  wire logic [lagc_pkg::NUM_TIMERS-1:0]     i_timer_start,
  output logic [7:0]                               o_reg_rdata,
  output logic                                     o_reg_hit,
  output logic                                     o_agc_active,
  output logic [6:0]                               o_gain_ceiling,
  output lagc_pkg::lagc_len_t                      o_attack_len,
  output lagc_pkg::lagc_len_t                      o_decay_len,
  output lagc_pkg::lagc_len_t                      o_noise_deb_len,
  output lagc_pkg::lagc_len_t                      o_signal_deb_len,
  output logic [lagc_pkg::NUM_TIMERS-1:0]          o_timer_busy,
  output logic [lagc_pkg::NUM_TIMERS-1:0]          o_timer_done
);

  // ==========================================================================
  // register storage
  logic [7:0] gain_q,   gain_d;
  logic [7:0] attack_q, attack_d;
  logic [7:0] decay_q,  decay_d;
  logic [7:0] noise_q,  noise_d;
  logic [7:0] signal_q, signal_d;
  logic [7:0] rdata_d;
  logic       hit_d;

  // next register values and read answer
  always_comb begin
    gain_d   = gain_q;
    attack_d = attack_q;
    decay_d  = decay_q;
    noise_d  = noise_q;
    signal_d = signal_q;
    rdata_d  = 8'h00;
    hit_d    = 1'b0;
    if (i_reg_sel) begin
      case (i_reg_addr)
        lagc_pkg::OFS_GAIN_CEIL: begin
          hit_d   = 1'b1;
          rdata_d = gain_q;
          if (i_reg_we) begin
            gain_d = i_reg_wdata & lagc_pkg::MASK_GAIN_CEIL;
          end
        end
        lagc_pkg::OFS_ATTACK: begin
          hit_d   = 1'b1;
          rdata_d = attack_q;
          if (i_reg_we) begin
            attack_d = i_reg_wdata;
          end
        end
        lagc_pkg::OFS_DECAY: begin
          hit_d   = 1'b1;
          rdata_d = decay_q;
          if (i_reg_we) begin
            decay_d = i_reg_wdata;
          end
        end
        lagc_pkg::OFS_NOISE_DEB: begin
          hit_d   = 1'b1;
          rdata_d = noise_q;
          if (i_reg_we) begin
            noise_d = i_reg_wdata & lagc_pkg::MASK_NOISE;
          end
        end
        lagc_pkg::OFS_SIGNAL_DEB: begin
          hit_d   = 1'b1;
          rdata_d = signal_q;
          if (i_reg_we) begin
            signal_d = i_reg_wdata & lagc_pkg::MASK_SIGNAL;
          end
        end
        default: begin
          hit_d   = 1'b0;
          rdata_d = 8'h00;
        end
      endcase
      if (i_reg_we) begin
        rdata_d = 8'h00;
      end
    end
  end

  // register bank flops
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_q      <= lagc_pkg::RST_GAIN_CEIL;
      attack_q    <= lagc_pkg::RST_TIMING;
      decay_q     <= lagc_pkg::RST_TIMING;
      noise_q     <= lagc_pkg::RST_DEBOUNCE;
      signal_q    <= lagc_pkg::RST_DEBOUNCE;
      o_reg_rdata <= 8'h00;
      o_reg_hit   <= 1'b0;
    end else begin
      gain_q      <= gain_d;
      attack_q    <= attack_d;
      decay_q     <= decay_d;
      noise_q     <= noise_d;
      signal_q    <= signal_d;
      o_reg_rdata <= rdata_d;
      o_reg_hit   <= hit_d;
    end
  end

  // ==========================================================================
  // configuration decode
  lagc_pkg::lagc_cfg_s cfg;
  lagc_pkg::lagc_len_t attack_len, decay_len, noise_len, signal_len;
  logic [6:0]          ceil_d;

  assign cfg.gain     = gain_q[6:0];
  assign cfg.atk_code = attack_q[lagc_pkg::TIME_CODE_MSB:lagc_pkg::TIME_CODE_LSB];
  assign cfg.atk_mult = attack_q[lagc_pkg::MULT_MSB:lagc_pkg::MULT_LSB];
  assign cfg.dec_code = decay_q[lagc_pkg::TIME_CODE_MSB:lagc_pkg::TIME_CODE_LSB];
  assign cfg.dec_mult = decay_q[lagc_pkg::MULT_MSB:lagc_pkg::MULT_LSB];
  assign cfg.noise    = noise_q[4:0];
  assign cfg.signal   = signal_q[3:0];

  lagc_time_decode u_decode (
    .i_cfg        (cfg),
    .o_attack_len (attack_len),
    .o_decay_len  (decay_len),
    .o_noise_len  (noise_len),
    .o_signal_len (signal_len)
  );

  // effective ceiling, reserved codes clamp to the top valid code
  always_comb begin
    if (cfg.gain > lagc_pkg::CEIL_MAX_CODE) begin
      ceil_d = lagc_pkg::CEIL_MAX_CODE;
    end else begin
      ceil_d = cfg.gain;
    end
  end

  // decoded outputs registered
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gain_ceiling   <= 7'h00;
      o_attack_len     <= '0;
      o_decay_len      <= '0;
      o_noise_deb_len  <= '0;
      o_signal_deb_len <= '0;
      o_agc_active     <= 1'b0;
    end else begin
      o_gain_ceiling   <= ceil_d;
      o_attack_len     <= attack_len;
      o_decay_len      <= decay_len;
      o_noise_deb_len  <= noise_len;
      o_signal_deb_len <= signal_len;
      o_agc_active     <= i_agc_enable;
    end
  end

  // ==========================================================================
  // interval timers, one per attack, decay, noise and signal interval
  lagc_pkg::lagc_len_t len_arr [lagc_pkg::NUM_TIMERS];

  assign len_arr[lagc_pkg::TMR_ATTACK] = o_attack_len;
  assign len_arr[lagc_pkg::TMR_DECAY]  = o_decay_len;
  assign len_arr[lagc_pkg::TMR_NOISE]  = o_noise_deb_len;
  assign len_arr[lagc_pkg::TMR_SIGNAL] = o_signal_deb_len;

  for (genvar k = 0; k < lagc_pkg::NUM_TIMERS; k++) begin : g_timer
    lagc_interval_timer #(
      .LEN_W (lagc_pkg::LEN_W)
    ) u_timer (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_enable   (o_agc_active),
      .i_fs_tick  (i_fs_tick),
      .i_start    (i_timer_start[k]),
      .i_length   (len_arr[k]),
      .o_busy     (o_timer_busy[k]),
      .o_done     (o_timer_done[k])
    );
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_ceiling_cap: assert property (
    !$past(i_rst) |-> o_gain_ceiling ==
      (($past(gain_q[6:0]) > 7'h50) ? 7'h50 : $past(gain_q[6:0])))
    else $error("gain ceiling not capped at 40 dB code");

  chk_attack_units: assert property (
    (!$past(i_rst) && $past(attack_q[2:0]) == 3'h0) |->
      o_attack_len == lagc_pkg::lagc_len_t'(32 * (2 * int'($past(attack_q[7:3])) + 1)))
    else $error("attack time units wrong");

  chk_attack_mult: assert property (
    !$past(i_rst) |-> o_attack_len == lagc_pkg::lagc_len_t'(
      (32 * (2 * int'($past(attack_q[7:3])) + 1)) << $past(attack_q[2:0])))
    else $error("attack multiplier wrong");

  chk_decay_units: assert property (
    (!$past(i_rst) && $past(decay_q[2:0]) == 3'h0) |->
      o_decay_len == lagc_pkg::lagc_len_t'(512 * (2 * int'($past(decay_q[7:3])) + 1)))
    else $error("decay time units wrong");

  chk_decay_mult: assert property (
    !$past(i_rst) |-> o_decay_len == lagc_pkg::lagc_len_t'(
      (512 * (2 * int'($past(decay_q[7:3])) + 1)) << $past(decay_q[2:0])))
    else $error("decay multiplier wrong");

  chk_noise_table: assert property (
    (!$past(i_rst) && $past(noise_q) >= 8'h01 && $past(noise_q) <= 8'h0A) |->
      o_noise_deb_len == lagc_pkg::lagc_len_t'(4 << ($past(noise_q) - 8'h01)))
    else $error("noise debounce doubling step wrong");

  chk_noise_zero: assert property (
    (!$past(i_rst) && $past(noise_q) == 8'h00) |-> o_noise_deb_len == '0)
    else $error("noise debounce zero code wrong");

  chk_noise_mult: assert property (
    (!$past(i_rst) && $past(noise_q) >= 8'h0B) |-> o_noise_deb_len == lagc_pkg::lagc_len_t'(
      4096 * ((int'($past(noise_q)) > 29) ? 20 : (int'($past(noise_q)) - 9))))
    else $error("noise debounce multiple wrong");

  chk_signal_table: assert property (
    (!$past(i_rst) && $past(signal_q) >= 8'h0B) |->
      o_signal_deb_len == lagc_pkg::lagc_len_t'(2048 * (int'($past(signal_q)) - 9)))
    else $error("signal debounce multiple wrong");

  chk_signal_double: assert property (
    (!$past(i_rst) && $past(signal_q) >= 8'h01 && $past(signal_q) <= 8'h0A) |->
      o_signal_deb_len == lagc_pkg::lagc_len_t'(4 << ($past(signal_q) - 8'h01)))
    else $error("signal debounce doubling step wrong");

  chk_signal_zero: assert property (
    (!$past(i_rst) && $past(signal_q) == 8'h00) |-> o_signal_deb_len == '0)
    else $error("signal debounce zero code wrong");

  // ==========================================================================
  // register port and timer checks
  chk_reserved_zero: assert property (
    (i_reg_sel && !i_reg_we && i_reg_addr == 8'h5C) |=> o_reg_rdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  chk_write_masked: assert property (
    (i_reg_sel && i_reg_we && i_reg_addr == lagc_pkg::OFS_NOISE_DEB) |=>
      noise_q == ($past(i_reg_wdata) & lagc_pkg::MASK_NOISE))
    else $error("noise debounce write not stored masked");

  chk_read_answer: assert property (
    (i_reg_sel && !i_reg_we && i_reg_addr == lagc_pkg::OFS_GAIN_CEIL) |=>
      (o_reg_hit && o_reg_rdata == $past(gain_q) && !o_reg_rdata[7]))
    else $error("gain ceiling read answer wrong");

  // two disabled cycles in a row leave every timer idle for two cycles
  chk_disabled_idle: assert property (
    (!o_agc_active ##1 !o_agc_active) |-> (o_timer_busy == '0) ##1 (o_timer_busy == '0))
    else $error("timer runs while disabled");

  chk_active_follow: assert property (
    !$past(i_rst) |-> o_agc_active == $past(i_agc_enable))
    else $error("active flag does not follow enable");

  chk_zero_length: assert property (
    (o_agc_active && i_timer_start[2] && o_noise_deb_len == '0) |=>
      (o_timer_done[2] && !o_timer_busy[2]))
    else $error("zero noise debounce did not finish at once");

  chk_tick_expiry: assert property (
    (o_agc_active && i_timer_start[0] && o_attack_len == lagc_pkg::lagc_len_t'(32)
      && !i_fs_tick)
      ##1 (o_agc_active && !i_fs_tick && !i_timer_start[0]) |=> !o_timer_done[0])
    else $error("attack timer expired without sample tick");

  chk_busy_hold: assert property (
    (o_agc_active && o_timer_busy[1] && !i_fs_tick && !i_timer_start[1]) |=> o_timer_busy[1])
    else $error("decay timer stopped without sample tick");

  cov_attack_done: cover property (o_agc_active && o_timer_done[0]);
  cov_noise_done: cover property (o_agc_active && o_timer_done[2]);
  cov_ceiling_clamp: cover property (gain_q[6:0] > 7'h50 ##1 o_gain_ceiling == 7'h50);
  cov_signal_top: cover property (
    signal_q == 8'h0F ##1 o_signal_deb_len == lagc_pkg::lagc_len_t'(12288));

endmodule

//--- lagc_pkg.sv
package lagc_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_GAIN_CEIL  = 8'h58;
  localparam logic [7:0] OFS_ATTACK     = 8'h59;
  localparam logic [7:0] OFS_DECAY      = 8'h5A;
  localparam logic [7:0] OFS_NOISE_DEB  = 8'h5B;
  localparam logic [7:0] OFS_SIGNAL_DEB = 8'h5C;

  // ==========================================================================
  // reset values and writable-bit masks
  localparam logic [7:0] RST_GAIN_CEIL  = 8'h7F;
  localparam logic [7:0] RST_TIMING     = 8'h00;
  localparam logic [7:0] RST_DEBOUNCE   = 8'h00;
  localparam logic [7:0] MASK_GAIN_CEIL = 8'h7F;
  localparam logic [7:0] MASK_NOISE     = 8'h1F;
  localparam logic [7:0] MASK_SIGNAL    = 8'h0F;

  // ==========================================================================
  // field positions inside the timing registers
  localparam int TIME_CODE_LSB = 3;
  localparam int TIME_CODE_MSB = 7;
  localparam int MULT_LSB      = 0;
  localparam int MULT_MSB      = 2;

  // ==========================================================================
  // decode constants, all counts in sample periods
  localparam logic [6:0] CEIL_MAX_CODE     = 7'h50;
  localparam int         ATTACK_UNIT_SHIFT = 5;
  localparam int         DECAY_UNIT_SHIFT  = 9;
  localparam int         DEB_BASE_SHIFT    = 2;
  localparam logic [4:0] DEB_LIN_LAST      = 5'h0A;
  localparam logic [4:0] DEB_MULT_OFFSET   = 5'h09;
  localparam logic [4:0] DEB_MULT_MAX      = 5'h14;
  localparam int         NOISE_UNIT_SHIFT  = 12;
  localparam int         SIGNAL_UNIT_SHIFT = 11;

  // ==========================================================================
  // interval timers
  localparam int LEN_W       = 22;
  localparam int NUM_TIMERS  = 4;
  localparam int TMR_ATTACK  = 0;
  localparam int TMR_DECAY   = 1;
  localparam int TMR_NOISE   = 2;
  localparam int TMR_SIGNAL  = 3;

  typedef logic [LEN_W-1:0] lagc_len_t;

  typedef enum logic [0:0] {
    TMR_IDLE = 1'b0,
    TMR_RUN  = 1'b1
  } lagc_tmr_state_e;

  // ==========================================================================
  // configuration carried from the register bank to the decoder
  typedef struct packed {
    logic [6:0] gain;
    logic [4:0] atk_code;
    logic [2:0] atk_mult;
    logic [4:0] dec_code;
    logic [2:0] dec_mult;
    logic [4:0] noise;
    logic [3:0] signal;
  } lagc_cfg_s;

endpackage

//--- lagc_time_decode.sv
`timescale 1ns/1ns
module lagc_time_decode (
  input  wire lagc_pkg::lagc_cfg_s i_cfg,
  output lagc_pkg::lagc_len_t      o_attack_len,
  output lagc_pkg::lagc_len_t      o_decay_len,
  output lagc_pkg::lagc_len_t      o_noise_len,
  output lagc_pkg::lagc_len_t      o_signal_len
);

  // ==========================================================================
  // debounce table: zero, doubling from 4, then multiples of a large unit
  function automatic lagc_pkg::lagc_len_t deb_len(input logic [4:0] code,
                                                  input int unit_shift);
    logic [4:0] mult;
    mult = 5'h00;
    if (code == 5'h00) begin
      deb_len = '0;
    end else if (code <= lagc_pkg::DEB_LIN_LAST) begin
      deb_len = lagc_pkg::lagc_len_t'(1) << (lagc_pkg::DEB_BASE_SHIFT + int'(code) - 1);
    end else begin
      mult = code - lagc_pkg::DEB_MULT_OFFSET;
      if (mult > lagc_pkg::DEB_MULT_MAX) begin
        mult = lagc_pkg::DEB_MULT_MAX;
      end
      deb_len = lagc_pkg::lagc_len_t'(mult) << unit_shift;
    end
  endfunction

  // ==========================================================================
  // odd unit count times base unit, scaled by a power of two
  // attack odd units
  assign o_attack_len = lagc_pkg::lagc_len_t'({i_cfg.atk_code, 1'b1})
                        << (lagc_pkg::ATTACK_UNIT_SHIFT + int'(i_cfg.atk_mult));
  assign o_decay_len  = lagc_pkg::lagc_len_t'({i_cfg.dec_code, 1'b1})
                        << (lagc_pkg::DECAY_UNIT_SHIFT + int'(i_cfg.dec_mult));
  assign o_noise_len  = deb_len(i_cfg.noise, lagc_pkg::NOISE_UNIT_SHIFT);
  assign o_signal_len = deb_len({1'b0, i_cfg.signal}, lagc_pkg::SIGNAL_UNIT_SHIFT);

endmodule

//--- lagc_interval_timer.sv
`timescale 1ns/1ns
module lagc_interval_timer #(
  parameter int LEN_W = lagc_pkg::LEN_W
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_enable,
  input  wire logic             i_fs_tick,
  input  wire logic             i_start,
  input  wire logic [LEN_W-1:0] i_length,
  output logic                  o_busy,
  output logic                  o_done
);

  lagc_pkg::lagc_tmr_state_e state_q, state_d;
  logic [LEN_W-1:0]          cnt_q, cnt_d;
  logic                      done_d;

  // ==========================================================================
  // next state: load on start, count sample ticks, pulse on expiry
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    if (!i_enable) begin
      state_d = lagc_pkg::TMR_IDLE;
      cnt_d   = '0;
    end else if (i_start) begin
      if (i_length == '0) begin
        done_d  = 1'b1;
        state_d = lagc_pkg::TMR_IDLE;
      end else begin
        cnt_d   = i_length;
        state_d = lagc_pkg::TMR_RUN;
      end
    end else begin
      case (state_q)
        lagc_pkg::TMR_IDLE: begin
          cnt_d = cnt_q;
        end
        lagc_pkg::TMR_RUN: begin
          if (i_fs_tick) begin
            cnt_d = cnt_q - LEN_W'(1);
            if (cnt_q == LEN_W'(1)) begin
              done_d  = 1'b1;
              state_d = lagc_pkg::TMR_IDLE;
            end
          end
        end
        default: begin
          state_d = lagc_pkg::TMR_IDLE;
        end
      endcase
    end
  end

  // registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= lagc_pkg::TMR_IDLE;
      cnt_q   <= '0;
      o_done  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      o_done  <= done_d;
    end
  end

  assign o_busy = (state_q == lagc_pkg::TMR_RUN);

endmodule

//--- lagc_timing_regs_tb_top.sv
`timescale 1ns/1ns
module lagc_timing_regs_tb_top;
  // ==========================================================================
  // signals and counters
  logic        i_core_clk;
  logic        i_rst;
  logic        i_fs_tick;
  logic        i_agc_enable;
  logic        i_reg_sel;
  logic        i_reg_we;
  logic [7:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata;
  logic [3:0]  i_timer_start;
  logic [7:0]  o_reg_rdata;
  logic        o_reg_hit;
  logic        o_agc_active;
  logic [6:0]  o_gain_ceiling;
  logic [21:0] o_attack_len;
  logic [21:0] o_decay_len;
  logic [21:0] o_noise_deb_len;
  logic [21:0] o_signal_deb_len;
  logic [3:0]  o_timer_busy;
  logic [3:0]  o_timer_done;
  int          n_fail;
  int          check_count;
  int          cyc;
  logic [7:0]  rd;
  logic        hit;
  logic [7:0]  v;

  lagc_timing_regs u_lagc_timing_regs (
    .i_core_clk      (i_core_clk),
    .i_rst           (i_rst),
    .i_fs_tick       (i_fs_tick),
    .i_agc_enable    (i_agc_enable),
    .i_reg_sel       (i_reg_sel),
    .i_reg_we        (i_reg_we),
    .i_reg_addr      (i_reg_addr),
    .i_reg_wdata     (i_reg_wdata),
    .i_timer_start   (i_timer_start),
    .o_reg_rdata     (o_reg_rdata),
    .o_reg_hit       (o_reg_hit),
    .o_agc_active    (o_agc_active),
    .o_gain_ceiling  (o_gain_ceiling),
    .o_attack_len    (o_attack_len),
    .o_decay_len     (o_decay_len),
    .o_noise_deb_len (o_noise_deb_len),
    .o_signal_deb_len(o_signal_deb_len),
    .o_timer_busy    (o_timer_busy),
    .o_timer_done    (o_timer_done)
  );

  // ==========================================================================
  // clock and cycle ceiling
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge i_core_clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      $display("BAD %0t cycle ceiling reached", $time);
      finish_test();
    end
  end

  // ==========================================================================
  // helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one access, answer sampled after the edge that takes it
  task automatic reg_acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_sel   <= 1'b1;
    i_reg_we    <= we;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_sel <= 1'b0;
    #1;
    rd  = o_reg_rdata;
    hit = o_reg_hit;
  endtask

  // write, read back, and let the decoded lengths settle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    reg_acc(1'b1, a, d);
    chk(32'(hit), 32'h1, "write hit");
    reg_acc(1'b0, a, 8'h00);
    chk(32'(rd), 32'(exp), "readback");
  endtask

  function automatic logic [31:0] exp_time(input logic [7:0] r, input int sh);
    int n;
    n = int'(r[7:3]);
    return 32'((2 * n + 1) << (int'(r[2:0]) + sh));
  endfunction

  function automatic logic [31:0] exp_deb(input int c, input int unit);
    int m;
    if (c == 0) return 32'h0;
    if (c <= 10) return 32'(4 << (c - 1));
    m = c - 9;
    if (m > 20) m = 20;
    return 32'(m * unit);
  endfunction

  // start timer k and feed l ticks with random gaps
  task automatic run_timer(input int k, input int l);
    @(posedge i_core_clk);
    i_timer_start[k] <= 1'b1;
    @(posedge i_core_clk);
    i_timer_start <= 4'h0;
    #1;
    if (l == 0) begin
      chk(32'(o_timer_done[k]), 32'h1, "zero length done");
    end else begin
      chk(32'(o_timer_busy[k]), 32'h1, "busy after start");
      for (int i = 0; i < l; i++) begin
        repeat ($urandom_range(0, 2)) @(posedge i_core_clk);
        @(posedge i_core_clk);
        i_fs_tick <= 1'b1;
        @(posedge i_core_clk);
        i_fs_tick <= 1'b0;
        #1;
        chk(32'(o_timer_done[k]), 32'(i == l - 1), "done on last tick");
      end
      @(posedge i_core_clk);
      #1;
      chk(32'(o_timer_done[k]), 32'h0, "done one cycle");
      chk(32'(o_timer_busy[k]), 32'h0, "idle after done");
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    i_rst = 1'b1;
    i_fs_tick = 1'b0;
    i_agc_enable = 1'b0;
    i_reg_sel = 1'b0;
    i_reg_we = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_timer_start = 4'h0;
    void'($urandom(24));
    repeat (20) @(posedge i_core_clk);
    chk(32'(o_reg_hit), 32'h0, "hit in reset");
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk(32'(o_attack_len), 32'd32, "reset attack");
    chk(32'(o_decay_len), 32'd512, "reset decay");
    chk(32'(o_gain_ceiling), 32'h50, "reset ceiling");
    // reset values through the register port
    reg_acc(1'b0, 8'h58, 8'h00);
    chk(32'(rd), 32'h7F, "reset gain reg");
    for (int a = 8'h59; a <= 8'h5C; a++) begin
      reg_acc(1'b0, 8'(a), 8'h00);
      chk(32'(rd), 32'h00, "reset reg");
    end
    // unmapped offsets are refused
    reg_acc(1'b1, 8'h5D, 8'hFF);
    chk(32'(hit), 32'h0, "unmapped write hit");
    reg_acc(1'b0, 8'h57, 8'h00);
    chk(32'(hit), 32'h0, "unmapped read hit");
    chk(32'(rd), 32'h00, "unmapped read data");
    wr_rd(8'h58, 8'h00, 8'h00);
    chk(32'(o_gain_ceiling), 32'h00, "ceiling 0 dB");
    wr_rd(8'h58, 8'h50, 8'h50);
    chk(32'(o_gain_ceiling), 32'h50, "ceiling 40 dB");
    // software keeps codes at or below the 40 dB code and bit 7 clear
    wr_rd(8'h58, 8'h4F, 8'h4F);
    chk(32'(o_gain_ceiling), 32'h4F, "ceiling 39.5 dB");
    wr_rd(8'h58, 8'h01, 8'h01);
    chk(32'(o_gain_ceiling), 32'h01, "ceiling 0.5 dB");
    v = 8'($urandom_range(0, 80));
    wr_rd(8'h58, v, v);
    chk(32'(o_gain_ceiling), 32'(v), "ceiling random");
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h07 : 8'($urandom_range(0, 255));
      wr_rd(8'h59, v, v);
      chk(32'(o_attack_len), exp_time(v, 5), "attack len");
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'hF8 : 8'($urandom_range(0, 255));
      wr_rd(8'h5A, v, v);
      chk(32'(o_decay_len), exp_time(v, 9), "decay len");
    end
    // every noise code, reserved bits written and read as zero
    for (int c = 0; c < 32; c++) begin
      wr_rd(8'h5B, 8'(c), 8'(c));
      chk(32'(o_noise_deb_len), exp_deb(c, 4096), "noise len");
    end
    // every signal code, reserved bits written and read as zero
    for (int c = 0; c < 16; c++) begin
      wr_rd(8'h5C, 8'(c), 8'(c));
      chk(32'(o_signal_deb_len), exp_deb(c, 2048), "signal len");
    end
    wr_rd(8'h59, 8'h00, 8'h00);
    wr_rd(8'h5A, 8'h00, 8'h00);
    wr_rd(8'h5B, 8'h01, 8'h01);
    wr_rd(8'h5C, 8'h02, 8'h02);
    @(posedge i_core_clk);
    i_timer_start <= 4'hF;
    @(posedge i_core_clk);
    i_timer_start <= 4'h0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk(32'(o_timer_busy), 32'h0, "start while disabled");
    chk(32'(o_agc_active), 32'h0, "inactive");
    @(posedge i_core_clk);
    i_agc_enable <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk(32'(o_agc_active), 32'h1, "active follows enable");
    run_timer(0, 32);
    run_timer(1, 512);
    run_timer(2, 4);
    run_timer(3, 8);
    wr_rd(8'h5B, 8'h00, 8'h00);
    run_timer(2, 0);
    // dropping the enable clears a running timer
    @(posedge i_core_clk);
    i_timer_start <= 4'h1;
    @(posedge i_core_clk);
    i_timer_start <= 4'h0;
    i_agc_enable <= 1'b0;
    #1;
    chk(32'(o_timer_busy[0]), 32'h1, "busy before disable");
    repeat (3) @(posedge i_core_clk);
    #1;
    chk(32'(o_timer_busy), 32'h0, "cleared on disable");
    finish_test();
  end
endmodule
